/* File: hdl/dpm_port_ctrl.sv */
// Host-side controller for one port of an asynchronous dual-port memory.
// Assumes the device sits on plain pins; one request at a time on req/ack.
// Behaviour
// (RQ1) Write framed by strobe, strobe rises first
// (RQ2) Write lanes chosen by low lane selects
// (RQ3) Read lanes chosen by low lane selects
// (RQ4) Read asserts select and output enable together
// (RQ5) Token read: token select, lanes all high
// (RQ6) Token access uses token select, port deselected
// (RQ7) Cross-port read waits flow-through delay
// (RQ8) Top word right mailbox, next left
// (RQ9) Writing opposite mailbox raises its interrupt
// (RQ10) Reading own mailbox clears own interrupt
// (RQ11) Reading opposite mailbox leaves interrupt alone
// (RQ12) Busy port cannot set opposite interrupt
// (RQ13) Busy port cannot clear own interrupt
// (RQ14) Contention grants one port, busy other
// (RQ15) Near-simultaneous contention still grants one
// (RQ16) Busy asserts fixed delay after contention
// (RQ17) Role high makes busy pins outputs
// (RQ18) Writes wait for settled busy input; only memory writes wait, token writes start without checking busy
// (RQ19) Four nine-bit lanes, select zero lowest
// (RQ20) Token write uses data bit zero only
// (RQ21) Selected needs low and high selects
// (RQ22) Busy held until winner leaves
// (RQ23) Never port and token select together
`timescale 1ns/1ns
`default_nettype none
module dpm_port_ctrl
	import dpm_pkg::*;
#(
	parameter int FLOW_WAIT = FLOW_CYC
)
(
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire logic                  req,
	input  wire dpm_pkg::dpm_op_t      req_op,
	input  wire logic [ADDR_W-1:0]     req_addr,
	input  wire logic [DATA_W-1:0]     req_wdata,
	input  wire logic [LANES-1:0]      req_lanes,
	input  wire logic                  req_cross,
	output logic                       ack,
	output logic [DATA_W-1:0]          rdata,
	output logic                       irq,
	output logic                       busy_seen,
	output logic [ADDR_W-1:0]          addr,
	output logic                       select_low_active,
	output logic                       select_high_active,
	output logic                       token_space_select_n,
	output logic [LANES-1:0]           lane_select_n,
	output logic                       wr_n,
	output logic                       oe_n,
	output logic [DATA_W-1:0]          dq_out,
	output logic                       dq_oe_n,
	input  wire logic [DATA_W-1:0]     dq_in,
	input  wire logic                  busy_n,
	input  wire logic                  int_n
);
	typedef enum {
		DPM_IDLE,
		DPM_SETUP,
		DPM_STROBE,
		DPM_RECOVER,
		DPM_DONE
	} dpm_state_t;

	dpm_sync_if sif ();
	dpm_sync u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.s        (sif.sync)
	);
	assign sif.busy_n_raw = busy_n;
	assign sif.int_n_raw  = int_n;
	assign sif.data_raw   = dq_in;

	dpm_state_t        state, next_state;
	logic [CNT_W-1:0]  cnt, next_cnt;
	dpm_op_t           op, next_op;
	logic              next_ack;
	logic [DATA_W-1:0] next_rdata;
	logic [ADDR_W-1:0] next_addr;
	logic              next_sel_lo, next_sel_hi, next_tok_n;
	logic [LANES-1:0]  next_lane_n;
	logic              next_wr_n, next_oe_n, next_dq_oe_n;
	logic [DATA_W-1:0] next_dq_out;
	logic              is_wr, is_tok;

	assign is_wr  = (op == DPM_WR_MEM) || (op == DPM_WR_TOKEN);
	assign is_tok = (op == DPM_RD_TOKEN) || (op == DPM_WR_TOKEN);

	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_op      = op;
		next_ack     = 1'b0;
		next_rdata   = rdata;
		next_addr    = addr;
		next_sel_lo  = select_low_active;
		next_sel_hi  = select_high_active;
		next_tok_n   = token_space_select_n;
		next_lane_n  = lane_select_n;
		next_wr_n    = wr_n;
		next_oe_n    = oe_n;
		next_dq_oe_n = dq_oe_n;
		next_dq_out  = dq_out;
		case (state)
		DPM_IDLE: begin
			if (req) begin
				next_op   = req_op;
				next_addr = req_addr;
				next_cnt  = CNT_W'(SETUP_CYC);
				if (req_op == DPM_RD_TOKEN || req_op == DPM_WR_TOKEN) begin
					// Port deselected, lanes high: never both selects
					next_tok_n  = 1'b0; // RQ6 RQ23
					next_lane_n = '1; // RQ5
					next_dq_out = {{(DATA_W-1){1'b0}}, req_wdata[0]}; // RQ20
				end else begin
					next_lane_n = req_lanes; // RQ19
					next_dq_out = req_wdata;
				end
				next_state = DPM_SETUP;
			end
		end
		DPM_SETUP: begin
			// Hold address stable; on memory writes let busy settle first
			if (cnt != '0)
				next_cnt = cnt - 1'b1;
			else if (!(req_op_wr(op) && !sif.busy_n)) begin // RQ18
				if (!is_tok) begin
					next_sel_lo = 1'b0; // RQ21
					next_sel_hi = 1'b1;
				end
				if (is_wr) begin
					next_wr_n    = 1'b0; // RQ2
					next_dq_oe_n = 1'b0;
					next_cnt     = CNT_W'(ACCESS_CYC);
				end else begin
					next_oe_n = 1'b0; // RQ3 RQ4
					// Synchroniser delay counted too, else rdata is stale
					next_cnt  = req_cross
						? CNT_W'(FLOW_WAIT + ACCESS_CYC + SYNC_CYC)
						: CNT_W'(ACCESS_CYC + SYNC_CYC); // RQ7
				end
				next_state = DPM_STROBE;
			end
		end
		DPM_STROBE: begin
			if (cnt != '0)
				next_cnt = cnt - 1'b1;
			else if (is_wr || sif.busy_n) begin // RQ14 RQ22
				// Strobe rises before select so it ends the write
				next_wr_n  = 1'b1; // RQ1
				next_oe_n  = 1'b1;
				next_rdata = sif.data;
				next_cnt   = CNT_W'(RECOV_CYC);
				next_state = DPM_RECOVER;
			end
		end
		DPM_RECOVER: begin
			next_sel_lo  = 1'b1;
			next_sel_hi  = 1'b0;
			next_tok_n   = 1'b1;
			next_dq_oe_n = 1'b1;
			if (cnt != '0)
				next_cnt = cnt - 1'b1;
			else begin
				next_ack   = 1'b1;
				next_state = DPM_DONE;
			end
		end
		DPM_DONE: begin
			next_lane_n = '1;
			next_state  = DPM_IDLE;
		end
		default: next_state = DPM_IDLE;
		endcase
	end

	function automatic logic req_op_wr(input dpm_op_t o);
		req_op_wr = (o == DPM_WR_MEM);
	endfunction

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state                <= DPM_IDLE;
			cnt                  <= '0;
			op                   <= DPM_RD_MEM;
			ack                  <= 1'b0;
			rdata                <= '0;
			addr                 <= '0;
			select_low_active    <= 1'b1;
			select_high_active   <= 1'b0;
			token_space_select_n <= 1'b1;
			lane_select_n        <= '1;
			wr_n                 <= 1'b1;
			oe_n                 <= 1'b1;
			dq_oe_n              <= 1'b1;
			dq_out               <= '0;
			irq                  <= 1'b0;
			busy_seen            <= 1'b0;
		end else begin
			state                <= next_state;
			cnt                  <= next_cnt;
			op                   <= next_op;
			ack                  <= next_ack;
			rdata                <= next_rdata;
			addr                 <= next_addr;
			select_low_active    <= next_sel_lo;
			select_high_active   <= next_sel_hi;
			token_space_select_n <= next_tok_n;
			lane_select_n        <= next_lane_n;
			wr_n                 <= next_wr_n;
			oe_n                 <= next_oe_n;
			dq_oe_n              <= next_dq_oe_n;
			dq_out               <= next_dq_out;
			irq                  <= !sif.int_n; // RQ9 RQ10
			busy_seen            <= !sif.busy_n; // RQ16
		end
	end
endmodule
`default_nettype wire

/* File: include/dpm_pkg.sv */
// Constants and types for the dual-port memory port controller.
// Assumes a 100 MHz core clock; all pin timings are counted in cycles.
package dpm_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_W        = 15;
	localparam int LANE_W        = 9;
	localparam int LANES         = 4;
	localparam int DATA_W        = LANE_W * LANES;
	localparam int TOKEN_ADDR_W  = 3;
	// Mailbox words, 32K array; the 16K part uses 14'h3FFF / 14'h3FFE
	localparam logic [ADDR_W-1:0] MBOX_RIGHT_32K = 15'h7FFF;
	localparam logic [ADDR_W-1:0] MBOX_LEFT_32K  = 15'h7FFE;
	localparam logic [ADDR_W-1:0] MBOX_RIGHT_16K = 15'h3FFF;
	localparam logic [ADDR_W-1:0] MBOX_LEFT_16K  = 15'h3FFE;
	// Access, busy, flow-through, setup and recovery times, ns
	localparam int T_ACCESS_NS = 30;
	localparam int T_BUSY_NS   = 30;
	localparam int T_FLOW_NS   = 40;
	localparam int T_SETUP_NS  = 20;
	localparam int T_RECOV_NS  = 20;
	localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_CYC   = (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOW_CYC   = (T_FLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOV_CYC  = (T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Pin edge to settled value, worst case: an edge may miss the first flop
	localparam int SYNC_CYC   = 4;
	localparam int CNT_W      = 4;
	typedef enum logic [1:0] {
		DPM_RD_MEM,
		DPM_WR_MEM,
		DPM_RD_TOKEN,
		DPM_WR_TOKEN
	} dpm_op_t;
endpackage

/* File: include/dpm_sync_if.sv */
// Carrier between the port controller and its pin synchroniser.
// Assumes a single clock; raw pins enter, settled levels leave.
`timescale 1ns/1ns
`default_nettype none
interface dpm_sync_if;
	logic                      busy_n_raw;
	logic                      int_n_raw;
	logic [dpm_pkg::DATA_W-1:0] data_raw;
	logic                      busy_n;
	logic                      int_n;
	logic [dpm_pkg::DATA_W-1:0] data;
	modport pins (output busy_n_raw, int_n_raw, data_raw,
		input busy_n, int_n, data);
	modport sync (input busy_n_raw, int_n_raw, data_raw,
		output busy_n, int_n, data);
endinterface
`default_nettype wire

/* File: hdl/dpm_sync.sv */
// Three-stage synchroniser for the device's asynchronous outputs.
// Assumes busy and interrupt pins are levels; data is read only after settle.
`timescale 1ns/1ns
`default_nettype none
module dpm_sync
	import dpm_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic nrst,
	dpm_sync_if.sync  s
);
	localparam int W = DATA_W + 2;
	logic [W-1:0] st1;
	logic [W-1:0] st2;
	logic [W-1:0] st3;
	logic [W-1:0] held;
	logic [W-1:0] next_held;

	// A change counts once stages two and three agree
	always_comb begin
		next_held = held;
		for (int i = 0; i < W; i++) begin
			if (st2[i] == st3[i])
				next_held[i] = st3[i];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st1  <= '1;
			st2  <= '1;
			st3  <= '1;
			held <= '1;
		end else begin
			st1  <= {s.busy_n_raw, s.int_n_raw, s.data_raw};
			st2  <= st1;
			st3  <= st2;
			held <= next_held;
		end
	end

	assign s.busy_n = held[W-1];
	assign s.int_n  = held[W-2];
	assign s.data   = held[DATA_W-1:0];
endmodule
`default_nettype wire

/* File: sim/dpm_port_ctrl_props.sv */
// Pin-level assertions for the port controller.
// Assumes binding to dpm_port_ctrl; a single clock domain.
`timescale 1ns/1ns
`default_nettype none
module dpm_port_ctrl_props
	import dpm_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              nrst,
	input wire logic              irq,
	input wire logic              busy_seen,
	input wire logic              select_low_active,
	input wire logic              select_high_active,
	input wire logic              token_space_select_n,
	input wire logic [LANES-1:0]  lane_select_n,
	input wire logic              wr_n,
	input wire logic              oe_n,
	input wire logic              dq_oe_n,
	input wire logic              busy_n,
	input wire logic              int_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire logic sel = !select_low_active && select_high_active;
	sequence int_held;
		$fell(int_n) ##1 !int_n [*5];
	endsequence
	sequence wr_on;
		sel && !wr_n;
	endsequence
	tok_desel_a: assert property (!token_space_select_n |-> !sel)
		else $error("token select with port selected");
	tok_lanes_a: assert property (!token_space_select_n |-> &lane_select_n)
		else $error("token access with a lane selected");
	wr_frame_a: assert property (wr_on |=> sel || wr_n)
		else $error("select dropped before strobe");
	wr_drive_a: assert property (!wr_n |-> !dq_oe_n && oe_n)
		else $error("write without bus drive");
	rd_sel_a: assert property (!oe_n && token_space_select_n |-> sel && dq_oe_n)
		else $error("read without select or with drive");
	sel_lanes_a: assert property (sel |-> lane_select_n != 4'hF)
		else $error("selected with no lane");
	irq_track_a: assert property (int_held |-> irq)
		else $error("interrupt not reported");
	busy_track_a: assert property (!busy_n [*6] |-> busy_seen)
		else $error("busy not reported");
	wr_busy_a: assert property ($fell(wr_n) && token_space_select_n |-> !busy_seen)
		else $error("write started while busy");
endmodule
bind dpm_port_ctrl dpm_port_ctrl_props u_props (.*);
`default_nettype wire

/* File: sim/dpm_dev_model.sv */
// Behavioural model of the left port of the dual-port memory.
// Assumes the bench plays the far port through busy_drv and peer_set.
`timescale 1ns/1ns
`default_nettype none
module dpm_dev_model
	import dpm_pkg::*;
(
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              select_low_active,
	input  wire logic              select_high_active,
	input  wire logic              token_space_select_n,
	input  wire logic [LANES-1:0]  lane_select_n,
	input  wire logic              wr_n,
	input  wire logic              oe_n,
	input  wire logic [DATA_W-1:0] dq_out,
	input  wire logic              busy_drv,
	input  wire logic              peer_set,
	output logic [DATA_W-1:0]      dq_in,
	output logic                   busy_n,
	output var logic               int_n,
	output var logic               peer_int_n
);
	logic [DATA_W-1:0] mem [64];
	logic [7:0]        tok;
	logic [DATA_W-1:0] rd;
	wire logic sel = !select_low_active && select_high_active;
	initial begin
		foreach (mem[i]) mem[i] = '0;
		tok = 8'hFF;
		int_n = 1'b1;
		peer_int_n = 1'b1;
	end
	// Arbitration outcome is played by the bench
	assign busy_n = busy_drv;
	always @(posedge wr_n) begin
		if (!token_space_select_n) begin
			tok[addr[2:0]] <= dq_out[0];
		end else if (sel) begin
			for (int i = 0; i < LANES; i++) begin
				if (!lane_select_n[i])
					mem[addr[5:0]][i*LANE_W +: LANE_W] <= dq_out[i*LANE_W +: LANE_W];
			end
			if (addr == MBOX_RIGHT_32K && busy_n)
				peer_int_n <= 1'b0;
		end
	end
	// Released lanes show inverted data, never a stale copy
	always_comb begin
		rd = ~mem[addr[5:0]];
		if (!oe_n && wr_n && !token_space_select_n)
			rd[LANE_W-1:0] = {8'h00, tok[addr[2:0]]};
		else if (!oe_n && wr_n && sel) begin
			for (int i = 0; i < LANES; i++) begin
				if (!lane_select_n[i])
					rd[i*LANE_W +: LANE_W] = mem[addr[5:0]][i*LANE_W +: LANE_W];
			end
		end
	end
	assign #(T_ACCESS_NS) dq_in = rd;
	always @(posedge peer_set) int_n = 1'b0;
	always @* begin
		if (sel && wr_n && !oe_n && addr == MBOX_LEFT_32K && busy_n)
			int_n = 1'b1;
	end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the port controller and device model.
// Assumes the model stands for the device; no random stimulus.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import dpm_pkg::*;
	typedef struct {dpm_op_t o; logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d; logic [LANES-1:0] n;
		logic [DATA_W-1:0] m, e;} dpm_row_t;
	logic core_clk = 0, nrst = 0, req = 0, req_cross = 0;
	logic busy_drv = 1, peer_set = 0;
	dpm_op_t req_op = DPM_RD_MEM;
	logic [ADDR_W-1:0] req_addr = '0, addr;
	logic [DATA_W-1:0] req_wdata = '0, rdata, dq_out, dq_in;
	logic [LANES-1:0] req_lanes = '1, lane_select_n;
	logic ack, irq, busy_seen, select_low_active, select_high_active;
	logic token_space_select_n, wr_n, oe_n, dq_oe_n, busy_n;
	logic int_n, peer_int_n;
	int err_total = 0, n_tests = 0;
	dpm_row_t rows [9] = '{
		'{DPM_WR_MEM, 15'h0005, 36'h123456789, 4'h0, '0, '0},
		'{DPM_RD_MEM, 15'h0005, '0, 4'h0, '1, 36'h123456789},
		'{DPM_WR_MEM, 15'h0005, '1, 4'hE, '0, '0},
		'{DPM_RD_MEM, 15'h0005, '0, 4'h0, '1, 36'h1234567FF},
		'{DPM_RD_MEM, 15'h0005, '0, 4'h7, 36'hFF8000000, 36'h123456789},
		'{DPM_WR_TOKEN, 15'h0003, 36'hFFFFFFFFE, 4'hF, '0, '0},
		'{DPM_RD_TOKEN, 15'h0003, '0, 4'hF, 36'h1, 36'h0},
		'{DPM_WR_TOKEN, 15'h0003, 36'h1, 4'hF, '0, '0},
		'{DPM_RD_TOKEN, 15'h0003, '0, 4'hF, 36'h1, 36'h1}};
	always #5 core_clk = ~core_clk;
	dpm_port_ctrl u_dpm_port_ctrl (.*);
	dpm_dev_model u_dpm_dev_model (.*);
	task automatic check(string nm, logic [DATA_W-1:0] s, e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic run(dpm_op_t o, logic [ADDR_W-1:0] a,
		logic [DATA_W-1:0] d, logic [LANES-1:0] n);
		int k;
		@(posedge core_clk) #1;
		req_op = o;
		req_addr = a;
		req_wdata = d;
		req_lanes = n;
		req = 1;
		@(posedge core_clk) #1 req = 0;
		for (k = 0; k < 200 && ack !== 1'b1; k++) @(posedge core_clk) #1;
		check("ack", ack, 1);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#50000 err_total++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge core_clk);
		#1 nrst = 1;
		foreach (rows[i]) begin
			req_cross = 1'(i % 2);
			run(rows[i].o, rows[i].a, rows[i].d, rows[i].n);
			if (rows[i].m != 0)
				check("rdata", rdata & rows[i].m, rows[i].e & rows[i].m);
			$display("row %0d done", i);
		end
		peer_set = 1;
		repeat (6) @(posedge core_clk) #1;
		check("irq set", irq, 1);
		run(DPM_RD_MEM, MBOX_RIGHT_32K, '0, 4'h0);
		check("peer int", peer_int_n, 1);
		run(DPM_WR_MEM, MBOX_RIGHT_32K, 36'h05A, 4'h0);
		check("peer int", peer_int_n, 0);
		check("irq kept", irq, 1);
		busy_drv = 0;
		fork
			run(DPM_RD_MEM, MBOX_LEFT_32K, '0, 4'h0);
			begin
				repeat (30) @(posedge core_clk) #1;
				check("irq busy", irq, 1);
				check("busy", busy_seen, 1);
				busy_drv = 1;
			end
		join
		repeat (6) @(posedge core_clk) #1;
		check("irq clear", irq, 0);
		$display("mailbox done");
		busy_drv = 0;
		fork
			run(DPM_WR_MEM, 15'h0009, 36'h0AB, 4'h0);
			begin
				repeat (30) @(posedge core_clk) #1;
				check("wr wait", wr_n, 1);
				busy_drv = 1;
			end
		join
		$display("busy write done");
		fork
			run(DPM_WR_MEM, 15'h0009, '1, 4'h0);
		join_none
		repeat (6) @(posedge core_clk) #1;
		disable fork;
		nrst = 0;
		#1 check("pins", {select_low_active, select_high_active,
			token_space_select_n, wr_n, dq_oe_n, oe_n, lane_select_n}, 10'h2FF);
		repeat (2) @(posedge core_clk) #1;
		req = 0;
		nrst = 1;
		run(DPM_RD_MEM, 15'h0005, '0, 4'h0);
		check("rdata", rdata, 36'h1234567FF);
		$display("reset done");
		stop_test();
	end
endmodule
`default_nettype wire
